/* emi_mac_irq_enable.sv */
`timescale 1ns/1ps
// Functional notes
// R1 - Late collision needs own and master enable
// R2 - Transmit abort needs own and master enable
// R3 - No carrier needs own and master enable
// R4 - Deferral exceeded needs own and master enable
// R5 - Transmit complete needs own and master enable
// R6 - Transmit underflow needs own and master enable
// R7 - Master enable low blocks every transmit interrupt
// R8 - Master enable and summary flag raise transmit
// R9 - Control frame gated by own and master
// R10 - Receive bus error gated by own and master
// R11 - Exactly two interrupt outputs, receive and transmit
// R12 - Transmit bus error gated by bit 24
// R13 - Descriptor unavailable gated by bit 23
// R14 - Reserved enable bits read zero, ignored
module emi_mac_irq_enable import emi_pkg::*; (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire emi_apb_req_t apb_req,
   output emi_apb_rsp_t apb_rsp,
   input wire emi_tx_ev_t tx_events,
   input wire emi_rx_ev_t rx_events,
   output logic tx_summary_irq,
   output logic rx_summary_irq
);

   // ****************************************************************
   // Declarations.
   // ****************************************************************
   // Current and next state of the block.
   emi_top_state_t st;
   emi_top_state_t next_st;
   // Event pulses placed at their status positions.
   logic [31:0] set_vec;
   // Write-one-to-clear strobes for the status register.
   logic [31:0] clr_vec;
   // Latched status flags.
   logic [31:0] flags;
   // Gated summaries before the master enable.
   logic tx_summary;
   logic rx_summary;
   // Status as software reads it, summaries included.
   logic [31:0] status_view;
   // Bus phase decodes.
   logic setup;
   logic access;
   logic hit_enable;
   logic hit_status;
   // Short name for the master enable bit.
   logic tx_master;

   // ****************************************************************
   // Bus decode.
   // ****************************************************************
   // Setup cycle of a transfer; the answer is prepared here.
   assign setup = apb_req.psel & ~apb_req.penable;
   // The edge at which the master samples pready high.
   assign access = apb_req.psel & apb_req.penable & st.rsp.pready;
   // Register hits.
   assign hit_enable = (apb_req.paddr == EMI_OFF_ENABLE);
   assign hit_status = (apb_req.paddr == EMI_OFF_STATUS);
   assign tx_master = st.mac_interrupt_enable[EMI_BIT_TX_MASTER];

   // ****************************************************************
   // Event capture.
   // ****************************************************************
   // Map incoming pulses onto their status bit positions.
   always_comb begin
      set_vec = '0;
      set_vec[EMI_BIT_TX_BUS_ERR:EMI_BIT_TX_LOW] = tx_events;
      set_vec[EMI_BIT_CONTROL_FRAME] = rx_events.control_frame_flag;
      set_vec[EMI_BIT_RX_BUS_ERR] = rx_events.rx_bus_error_flag;
   end

   // Writing a one to a source bit clears it; summaries are derived.
   always_comb begin
      clr_vec = '0;
      if (access && apb_req.pwrite && hit_status) begin
         clr_vec = apb_req.pwdata & (EMI_TX_SRC_MASK | EMI_RX_SRC_MASK);
      end
   end

   // Latched flags; a set in the clearing cycle survives.
   emi_sticky_flags #(
      .WIDTH(32)
   ) u_flags (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .set_vec(set_vec),
      .clr_vec(clr_vec),
      .flags(flags)
   );

   // ****************************************************************
   // Source masking.
   // ****************************************************************
   // Each source counts only with its own enable bit set.
   // Master gating comes later, so status bit 16 stays an ungated summary.
   emi_irq_gate u_gate (
      .flags(flags),
      .enable(st.mac_interrupt_enable),
      .tx_summary(tx_summary), // R1 R2 R3 R4 R5 R6 R12 R13
      .rx_summary(rx_summary) // R9 R10
   );

   // Status as read: sources plus the two derived summary bits.
   always_comb begin
      status_view = flags & (EMI_TX_SRC_MASK | EMI_RX_SRC_MASK);
      status_view[EMI_BIT_TX_MASTER] = tx_summary;
      status_view[EMI_BIT_RX_SUMMARY] = rx_summary;
   end

   // ****************************************************************
   // Next state.
   // ****************************************************************
   // The slave answers with no wait state: pready rises in the first
   // access cycle, so reads are captured in the setup cycle while the
   // address is already stable.
   // Limitation: a master that stretches the setup phase is not served;
   // pready always follows the setup edge by exactly one edge.
   always_comb begin
      next_st = st;
      next_st.rsp.pready = setup;
      if (setup) begin
         // Unmapped addresses answer with an error and read zero.
         next_st.rsp.pslverr = ~(hit_enable | hit_status);
         if (hit_enable) begin
            next_st.rsp.prdata = st.mac_interrupt_enable;
         end else if (hit_status) begin
            next_st.rsp.prdata = status_view;
         end else begin
            next_st.rsp.prdata = '0;
         end
      end else if (!apb_req.psel) begin
         // Idle bus: drop the answer so stale data is not shown.
         next_st.rsp.prdata = '0;
         next_st.rsp.pslverr = 1'b0;
      end
      // Only implemented enable bits are kept; reserved ones drop writes.
      if (access && apb_req.pwrite && hit_enable) begin
         next_st.mac_interrupt_enable = apb_req.pwdata & EMI_ENABLE_MASK; // R14
      end
      // The transmit master enable gates both lines, as documented.
      next_st.tx_summary_irq = tx_master & tx_summary; // R7 R8
      next_st.rx_summary_irq = tx_master & rx_summary; // R9 R10
   end

   // ****************************************************************
   // State register.
   // ****************************************************************
   // One register for the whole state; synchronous active-low reset.
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         st <= '{mac_interrupt_enable: EMI_ENABLE_RST,
                 rsp: '0,
                 tx_summary_irq: 1'b0,
                 rx_summary_irq: 1'b0};
      end else begin
         st <= next_st;
      end
   end

   // ****************************************************************
   // Outputs.
   // ****************************************************************
   // Exactly two interrupt lines leave the block, both registered.
   assign tx_summary_irq = st.tx_summary_irq; // R11
   assign rx_summary_irq = st.rx_summary_irq; // R11
   assign apb_rsp = st.rsp;

   // ****************************************************************
   // Assertions.
   // ****************************************************************
   default clocking emi_cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);

   // Short names for readability of the properties.
   logic [31:0] en;
   assign en = st.mac_interrupt_enable;

   property p_late_collision;
      flags[EMI_BIT_LATE_COLLISION] && en[EMI_BIT_LATE_COLLISION] && en[EMI_BIT_TX_MASTER]
         |=> tx_summary_irq;
   endproperty
   a_late_collision: assert property (p_late_collision) else $error("late collision lost"); // R1

   property p_tx_abort;
      flags[EMI_BIT_TX_ABORT] && en[EMI_BIT_TX_ABORT] && en[EMI_BIT_TX_MASTER]
         |=> tx_summary_irq;
   endproperty
   a_tx_abort: assert property (p_tx_abort) else $error("tx abort lost"); // R2

   property p_no_carrier_masked;
      (flags & en & EMI_TX_SRC_MASK) == (32'h1 << EMI_BIT_NO_CARRIER)
         ##1 !en[EMI_BIT_NO_CARRIER] && (flags & en & EMI_TX_SRC_MASK) == 32'h0
         |=> !tx_summary_irq;
   endproperty
   a_no_carrier_masked: assert property (p_no_carrier_masked) else $error("no carrier leak"); // R3

   property p_defer_exceeded;
      flags[EMI_BIT_DEFER_EXCEEDED] && en[EMI_BIT_DEFER_EXCEEDED] && en[EMI_BIT_TX_MASTER]
         |=> tx_summary_irq;
   endproperty
   a_defer_exceeded: assert property (p_defer_exceeded) else $error("defer lost"); // R4

   // An event reaches the line two edges later while enables hold.
   property p_tx_complete_path;
      tx_events.tx_complete_flag && en[EMI_BIT_TX_COMPLETE] && en[EMI_BIT_TX_MASTER]
         ##1 en[EMI_BIT_TX_COMPLETE] && en[EMI_BIT_TX_MASTER] |=> tx_summary_irq;
   endproperty
   a_tx_complete_path: assert property (p_tx_complete_path) else $error("tx done late"); // R5

   property p_tx_underflow;
      flags[EMI_BIT_TX_UNDERFLOW] && en[EMI_BIT_TX_UNDERFLOW] && en[EMI_BIT_TX_MASTER]
         |=> tx_summary_irq;
   endproperty
   a_tx_underflow: assert property (p_tx_underflow) else $error("underflow lost"); // R6

   property p_master_off;
      !en[EMI_BIT_TX_MASTER] |=> !tx_summary_irq && !rx_summary_irq;
   endproperty
   a_master_off: assert property (p_master_off) else $error("irq with master off"); // R7

   property p_summary_follows;
      en[EMI_BIT_TX_MASTER] |=> tx_summary_irq == $past(status_view[EMI_BIT_TX_MASTER]);
   endproperty
   a_summary_follows: assert property (p_summary_follows) else $error("tx line mismatch"); // R8

   property p_control_frame;
      flags[EMI_BIT_CONTROL_FRAME] && en[EMI_BIT_CONTROL_FRAME] && en[EMI_BIT_TX_MASTER]
         |=> rx_summary_irq;
   endproperty
   a_control_frame: assert property (p_control_frame) else $error("control frame lost"); // R9

   property p_rx_bus_error;
      flags[EMI_BIT_RX_BUS_ERR] && en[EMI_BIT_RX_BUS_ERR] && en[EMI_BIT_TX_MASTER]
         |=> rx_summary_irq;
   endproperty
   a_rx_bus_error: assert property (p_rx_bus_error) else $error("rx bus error lost"); // R10

   property p_rx_quiet;
      (flags & en & EMI_RX_SRC_MASK) == 32'h0 |=> !rx_summary_irq;
   endproperty
   a_rx_quiet: assert property (p_rx_quiet) else $error("spurious rx irq"); // R11

   property p_tx_bus_error;
      flags[EMI_BIT_TX_BUS_ERR] && en[EMI_BIT_TX_BUS_ERR] && en[EMI_BIT_TX_MASTER]
         |=> tx_summary_irq;
   endproperty
   a_tx_bus_error: assert property (p_tx_bus_error) else $error("tx bus error lost"); // R12

   property p_desc_unavail;
      flags[EMI_BIT_TX_DESC_UNAVAIL] && en[EMI_BIT_TX_DESC_UNAVAIL] && en[EMI_BIT_TX_MASTER]
         |=> tx_summary_irq;
   endproperty
   a_desc_unavail: assert property (p_desc_unavail) else $error("desc unavail lost"); // R13

   property p_reserved_zero;
      apb_rsp.pready && apb_req.paddr == EMI_OFF_ENABLE
         |-> (apb_rsp.prdata & EMI_RSV_MASK) == 32'h0 && (en & EMI_RSV_MASK) == 32'h0;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set"); // R14

   // A write lands whole at its access edge, minus the reserved bits.
   property p_enable_write;
      access && apb_req.pwrite && hit_enable
         |=> en == ($past(apb_req.pwdata) & EMI_ENABLE_MASK);
   endproperty
   a_enable_write: assert property (p_enable_write) else $error("enable write lost"); // R14

   // With no enabled transmit source latched, the line is low next cycle.
   property p_tx_quiet;
      (flags & en & EMI_TX_SRC_MASK) == 32'h0 |=> !tx_summary_irq;
   endproperty
   a_tx_quiet: assert property (p_tx_quiet) else $error("tx leak"); // R1 R2 R3 R4 R5 R6 R12 R13

   // Every event latches, even when software clears that bit in the same cycle.
   property p_set_lands;
      set_vec != 32'h0 |=> (flags & $past(set_vec)) == $past(set_vec);
   endproperty
   a_set_lands: assert property (p_set_lands) else $error("event lost on clear"); // R8

   // No wait states: pready follows setup at once and stands one cycle.
   property p_zero_wait;
      setup |=> apb_rsp.pready ##1 !apb_rsp.pready;
   endproperty
   a_zero_wait: assert property (p_zero_wait) else $error("pready timing");

   // ****************************************************************
   // Cover properties.
   // ****************************************************************
   // Main scenarios worth seeing in simulation.
   c_tx_irq: cover property ($rose(tx_summary_irq));
   c_rx_irq: cover property ($rose(rx_summary_irq));
   c_enable_write: cover property (access && apb_req.pwrite && hit_enable);
   c_status_clear: cover property (access && apb_req.pwrite && hit_status ##1 !tx_summary);
   c_set_wins: cover property ((set_vec & clr_vec) != 32'h0);

endmodule : emi_mac_irq_enable

/* emi_pkg.sv */
// ****************************************************************
// Shared constants and carrier types of the MAC interrupt masking stage.
// ****************************************************************
package emi_pkg;

   // ****************************************************************
   // Register map.
   // ****************************************************************
   // Width of the byte address that the slave decodes.
   localparam int unsigned EMI_ADDR_W = 12;
   // Byte offset of the interrupt enable register.
   localparam logic [11:0] EMI_OFF_ENABLE = 12'h0ac;
   // Byte offset of the latched interrupt status register.
   localparam logic [11:0] EMI_OFF_STATUS = 12'h0b0;
   // Reset value of the enable register: every source masked.
   localparam logic [31:0] EMI_ENABLE_RST = 32'h0000_0000;
   // Reset value of the status register: nothing latched.
   localparam logic [31:0] EMI_STATUS_RST = 32'h0000_0000;

   // ****************************************************************
   // Field positions, shared by enable and status.
   // ****************************************************************
   localparam int EMI_BIT_TX_BUS_ERR = 24;
   localparam int EMI_BIT_TX_DESC_UNAVAIL = 23;
   localparam int EMI_BIT_LATE_COLLISION = 22;
   localparam int EMI_BIT_TX_ABORT = 21;
   localparam int EMI_BIT_NO_CARRIER = 20;
   localparam int EMI_BIT_DEFER_EXCEEDED = 19;
   localparam int EMI_BIT_TX_COMPLETE = 18;
   localparam int EMI_BIT_TX_UNDERFLOW = 17;
   localparam int EMI_BIT_TX_MASTER = 16;
   localparam int EMI_BIT_CONTROL_FRAME = 14;
   localparam int EMI_BIT_RX_BUS_ERR = 11;
   localparam int EMI_BIT_RX_SUMMARY = 0;
   // Lowest bit of the contiguous transmit source group.
   localparam int EMI_BIT_TX_LOW = 17;

   // ****************************************************************
   // Field groups.
   // ****************************************************************
   // Enable bits that exist; all others read zero and drop writes.
   localparam logic [31:0] EMI_ENABLE_MASK = 32'h01ff_4800;
   // Latched transmit sources, bits 24 down to 17.
   localparam logic [31:0] EMI_TX_SRC_MASK = 32'h01fe_0000;
   // Latched receive sources handled here, bits 14 and 11.
   localparam logic [31:0] EMI_RX_SRC_MASK = 32'h0000_4800;
   // Reserved enable positions 15, 13 and 12.
   localparam logic [31:0] EMI_RSV_MASK = 32'h0000_b000;

   // ****************************************************************
   // Carrier types.
   // ****************************************************************
   // APB request as driven by the bus master.
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } emi_apb_req_t;

   // APB answer, every field from a flip-flop.
   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } emi_apb_rsp_t;

   // Transmit event pulses, ordered as status bits 24 down to 17.
   typedef struct packed {
      logic tx_bus_error_flag;
      logic tx_desc_unavail_flag;
      logic late_collision_flag;
      logic tx_abort_flag;
      logic no_carrier_flag;
      logic defer_exceeded_flag;
      logic tx_complete_flag;
      logic tx_underflow_flag;
   } emi_tx_ev_t;

   // Receive event pulses handled by this stage.
   typedef struct packed {
      logic control_frame_flag;
      logic rx_bus_error_flag;
   } emi_rx_ev_t;

   // Whole state of the top module.
   typedef struct packed {
      logic [31:0] mac_interrupt_enable;
      emi_apb_rsp_t rsp;
      logic tx_summary_irq;
      logic rx_summary_irq;
   } emi_top_state_t;

endpackage : emi_pkg

/* emi_sticky_flags.sv */
`timescale 1ns/1ps
// ****************************************************************
// Sticky status flags with write-one-to-clear.
// ****************************************************************
module emi_sticky_flags import emi_pkg::*; #(
   parameter int WIDTH = 32
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] set_vec,
   input wire logic [WIDTH-1:0] clr_vec,
   output logic [WIDTH-1:0] flags
);

   // State of the module: the flag bits.
   typedef struct packed {
      logic [WIDTH-1:0] flags;
   } emi_sticky_state_t;

   // Current and next state.
   emi_sticky_state_t st;
   emi_sticky_state_t next_st;
   // Per-bit next values.
   logic [WIDTH-1:0] next_flags;

   // ****************************************************************
   // Per-bit update.
   // ****************************************************************
   // A set arriving with a clear wins, so no event is ever lost.
   for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      assign next_flags[i] = set_vec[i] | (st.flags[i] & ~clr_vec[i]);
   end

   // Fill the next state.
   always_comb begin
      next_st = st;
      next_st.flags = next_flags;
   end

   // Register the state; reset clears every flag.
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         st <= '{flags: '0};
      end else begin
         st <= next_st;
      end
   end

   assign flags = st.flags;

endmodule : emi_sticky_flags

/* emi_irq_gate.sv */
`timescale 1ns/1ps
// ****************************************************************
// Per-source masking of latched flags into the two summaries.
// ****************************************************************
module emi_irq_gate import emi_pkg::*; (
   input wire logic [31:0] flags,
   input wire logic [31:0] enable,
   output logic tx_summary,
   output logic rx_summary
);

   // Flags that survive their own enable bit.
   logic [31:0] masked;

   // ****************************************************************
   // Per-bit mask.
   // ****************************************************************
   // Only real source positions pass, so reserved bits never count.
   for (genvar i = 0; i < 32; i++) begin : g_mask
      assign masked[i] = flags[i] & enable[i] & (EMI_TX_SRC_MASK[i] | EMI_RX_SRC_MASK[i]);
   end

   // Summaries per direction; the master enable is applied by the caller.
   assign tx_summary = |(masked & EMI_TX_SRC_MASK);
   assign rx_summary = |(masked & EMI_RX_SRC_MASK);

endmodule : emi_irq_gate

/* emi_cpu_model.sv */
`timescale 1ns/1ps
// ****************************************************************
// Processor side of the two interrupt lines.
// ****************************************************************
module emi_cpu_model import emi_pkg::*; (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic tx_summary_irq,
   input wire logic rx_summary_irq,
   output logic [1:0] irq_lines,
   output logic [15:0] tx_entries,
   output logic [15:0] rx_entries
);
   // Line levels seen one cycle earlier, to spot handler entries.
   logic [1:0] prev_lines;

   // The core takes both lines as plain levels and latches nothing.
   // A level input means a missed edge cannot hide a pending source.
   assign irq_lines = {tx_summary_irq, rx_summary_irq};

   // Count each rising level once, as a handler entry would.
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         prev_lines <= 2'h0;
         tx_entries <= 16'h0000;
         rx_entries <= 16'h0000;
      end else begin
         prev_lines <= irq_lines;
         if (irq_lines[1] && !prev_lines[1]) begin
            tx_entries <= tx_entries + 16'h0001;
         end
         if (irq_lines[0] && !prev_lines[0]) begin
            rx_entries <= rx_entries + 16'h0001;
         end
      end
   end
endmodule : emi_cpu_model

/* tb_top.sv */
`timescale 1ns/1ps
// ****************************************************************
// Self-checking bench of the MAC interrupt masking stage.
// ****************************************************************
module tb_top import emi_pkg::*; ();
   logic core_clk; // System clock, 200 MHz.
   logic rst_n; // Synchronous reset, active low.
   emi_apb_req_t req; // Bus request driven by the bench.
   emi_apb_rsp_t rsp; // Bus answer of the design.
   emi_tx_ev_t tx_ev; // Transmit event pulses.
   emi_rx_ev_t rx_ev; // Receive event pulses.
   logic tx_irq; // Transmit interrupt line.
   logic rx_irq; // Receive interrupt line.
   logic [1:0] irq_lines; // Lines as the processor model sees them.
   logic probe; // Asks the monitor to compare the interrupt lines.
   logic [15:0] tx_entries; // Handler entries seen by the processor model.
   logic [15:0] rx_entries; // Receive handler entries.
   logic [32:0] exp_q[$]; // Expected results, oldest first.
   logic [31:0] rnd; // Random enable pattern.
   int n_mismatch; // Failed comparisons.
   int n_tests; // Comparisons made.
   int src[10] = '{EMI_BIT_TX_BUS_ERR, EMI_BIT_TX_DESC_UNAVAIL, EMI_BIT_LATE_COLLISION,
                   EMI_BIT_TX_ABORT, EMI_BIT_NO_CARRIER, EMI_BIT_DEFER_EXCEEDED,
                   EMI_BIT_TX_COMPLETE, EMI_BIT_TX_UNDERFLOW, EMI_BIT_CONTROL_FRAME,
                   EMI_BIT_RX_BUS_ERR};

   emi_mac_irq_enable DUT (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .apb_req(req),
      .apb_rsp(rsp),
      .tx_events(tx_ev),
      .rx_events(rx_ev),
      .tx_summary_irq(tx_irq),
      .rx_summary_irq(rx_irq)
   );

   emi_cpu_model cpu (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .tx_summary_irq(tx_irq),
      .rx_summary_irq(rx_irq),
      .irq_lines(irq_lines),
      .tx_entries(tx_entries),
      .rx_entries(rx_entries)
   );

   // Free-running clock, 5 ns period.
   always #2.5 core_clk = ~core_clk;

   // ****************************************************************
   // Checking.
   // ****************************************************************
   // Print the counts and the verdict, then stop.
   task automatic conclude();
      // Leftover notes mean a result never appeared.
      if (exp_q.size() != 0) begin
         n_mismatch++;
         $display("MISMATCH t=%0t notes left %h exp %h", $time, exp_q.size(), 32'h0);
      end
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : conclude

   // Take the oldest note and compare it with an observed value.
   task automatic compare(input logic [32:0] got);
      logic [32:0] exp;
      n_tests++;
      if (exp_q.size() == 0) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got %h with no note", $time, got);
      end else begin
         exp = exp_q.pop_front();
         if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
         end
      end
   endtask : compare

   // Monitor samples at the rising edge, the same edge at which the master takes pready.
   always @(posedge core_clk) begin
      if (probe === 1'b1) begin
         compare({31'h0, irq_lines});
      end else if (req.psel && req.penable && !req.pwrite && rsp.pready === 1'b1) begin
         compare({rsp.pslverr, rsp.prdata});
      end
   end

   // ****************************************************************
   // Drivers.
   // ****************************************************************
   // One APB transfer; request held until the edge that sees pready.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge core_clk);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
      @(posedge core_clk);
      req.penable <= 1'b1;
      // Bounded wait; the rising edge that sees pready high ends the access.
      do begin
         @(posedge core_clk);
         n++;
      end while (rsp.pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         n_mismatch++;
         $display("MISMATCH t=%0t pready %h exp %h", $time, rsp.pready, 1'b1);
         conclude();
      end else begin
         // Release right after the sampling edge.
         req.psel <= 1'b0;
         req.penable <= 1'b0;
      end
   endtask : apb

   // Read with the expected {pslverr, prdata} noted first.
   task automatic rd(input logic [11:0] a, input logic [32:0] exp);
      exp_q.push_back(exp);
      apb(1'b0, a, 32'h0000_0000);
   endtask : rd

   // Note the expected lines, then ask for one comparison.
   task automatic chk_irq(input logic t, input logic r);
      exp_q.push_back({31'h0, t, r});
      @(posedge core_clk);
      probe <= 1'b1;
      @(posedge core_clk);
      probe <= 1'b0;
   endtask : chk_irq

   // One-cycle event pulse for the source at status bit b.
   task automatic pulse(input int b);
      @(posedge core_clk);
      if (b >= EMI_BIT_TX_LOW) begin
         tx_ev <= emi_tx_ev_t'(8'h01 << (b - EMI_BIT_TX_LOW));
      end else begin
         rx_ev <= (b == EMI_BIT_CONTROL_FRAME) ? 2'b10 : 2'b01;
      end
      @(posedge core_clk);
      tx_ev <= '0;
      rx_ev <= '0;
   endtask : pulse

   // ****************************************************************
   // Main sequence.
   // ****************************************************************
   initial begin
      logic [31:0] own;
      logic tx;
      core_clk = 1'b0;
      rst_n = 1'b0;
      req = '0;
      tx_ev = '0;
      rx_ev = '0;
      probe = 1'b0;
      n_mismatch = 0;
      n_tests = 0;
      void'($urandom(35));
      repeat (8) @(posedge core_clk);
      rst_n <= 1'b1;
      rd(EMI_OFF_ENABLE, {1'b0, EMI_ENABLE_RST});
      rd(EMI_OFF_STATUS, {1'b0, EMI_STATUS_RST});
      chk_irq(1'b0, 1'b0);
      // Random pattern with every reserved bit forced high.
      rnd = $urandom | EMI_RSV_MASK;
      apb(1'b1, EMI_OFF_ENABLE, rnd);
      rd(EMI_OFF_ENABLE, {1'b0, rnd & EMI_ENABLE_MASK});
      chk_irq(1'b0, 1'b0);
      // Unmapped place: error answer, reads zero, write dropped.
      apb(1'b1, 12'h0f0, 32'hffff_ffff);
      rd(12'h0f0, {1'b1, 32'h0000_0000});
      rd(EMI_OFF_ENABLE, {1'b0, rnd & EMI_ENABLE_MASK});
      // Every source in turn, through own-only, master-only and both-enables settings.
      foreach (src[i]) begin
         own = 32'h1 << src[i];
         tx = (src[i] >= EMI_BIT_TX_LOW);
         apb(1'b1, EMI_OFF_ENABLE, own);
         repeat ($urandom_range(0, 3)) @(posedge core_clk);
         pulse(src[i]);
         chk_irq(1'b0, 1'b0);
         rd(EMI_OFF_STATUS, {1'b0, own | (tx ? 32'h0001_0000 : 32'h1)});
         apb(1'b1, EMI_OFF_ENABLE, own | 32'h0001_0000);
         chk_irq(tx, !tx);
         apb(1'b1, EMI_OFF_ENABLE, 32'h0001_0000);
         chk_irq(1'b0, 1'b0);
         apb(1'b1, EMI_OFF_ENABLE, own | 32'h0001_0000 | EMI_RSV_MASK);
         chk_irq(tx, !tx);
         // Clearing the flag must drop the line one cycle later.
         apb(1'b1, EMI_OFF_STATUS, own);
         chk_irq(1'b0, 1'b0);
         rd(EMI_OFF_STATUS, {1'b0, 32'h0000_0000});
         // A live event with both enables set reaches the line directly.
         pulse(src[i]);
         chk_irq(tx, !tx);
         // An event in the very cycle of its clear must survive it.
         fork
            apb(1'b1, EMI_OFF_STATUS, own);
            begin
               @(posedge core_clk);
               pulse(src[i]);
            end
         join
         chk_irq(tx, !tx);
         apb(1'b1, EMI_OFF_STATUS, own);
         chk_irq(1'b0, 1'b0);
      end
      // Each source raises its own line three times: two enable steps, one live pulse.
      @(posedge core_clk);
      exp_q.push_back({17'h0_0000, 16'h0018});
      compare({17'h0_0000, tx_entries});
      exp_q.push_back({17'h0_0000, 16'h0006});
      compare({17'h0_0000, rx_entries});
      conclude();
   end

   // Guard against a hang anywhere in the sequence.
   initial begin
      #200000;
      n_mismatch++;
      conclude();
   end
endmodule : tb_top
